// ### user_timing_signal_combiner.sv
// Purpose: Fourth user timing output, extended audio key, line reset
// Assumes: AHB-Lite single word transfers, pixel enable from divider
// Notes:   Zero wait states; all responses OKAY
//
// Contract
// R1: Vertical component begins at the programmed start line.
// R2: Vertical component ends at the programmed stop line.
// R3: Interlaced start and stop lines count within the odd field.
// R4: Software keeps start line below stop line.
// R5: Software keeps stop line within lines per field.
// R6: Software writes zero to reserved bits.
// R7: Operator bit 3 sets polarity; resets to 1, active low.
// R8: Bit 2 set gives AND of components, ignoring bits 1 and 0.
// R9: Bit 1 set, bit 2 clear gives OR, ignoring bit 0.
// R10: Only bit 0 set gives XOR of the components.
// R11: Extended audio enabled only while key register holds 20C1h.
// R12: Software also sets standard selector and lock mask bits.
// R13: Software applies the key through the update bit elsewhere.
// R14: Toggling counter-reset bit 15 resets the line-based counters.
// R15: Software waits for reference re-detection before toggling.
// R16: Software toggles reset when deserializer input switches upstream.
// R17: Horizontal component begins at the programmed start pixel.
// R18: Horizontal component ends at the programmed stop pixel.
// R19: Vertical component active from start to stop line every field; when interlaced, the code gates it to the odd field only.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module user_timing_signal_combiner #(
  parameter int PIXEL_DIV = 1
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Timing outputs
  output logic             final_signal_a,
  output logic             extended_audio_enable
);

  // Divider counter is 16 bits wide, so larger ratios cannot be served
  if (PIXEL_DIV < 1 || PIXEL_DIV > 65535) begin : g_bad_div
    $error("PIXEL_DIV out of range");
  end

  localparam int LINE_W = user_timing_pkg::LINE_W;

  line_position_if pos ();

  // Software visible state
  logic [15:0] hstart, hstop, oper, extaud, lnrst, format;
  logic [14:0] vstart, vstop;
  logic [15:0] next_hstart, next_hstop, next_oper, next_extaud;
  logic [15:0] next_lnrst, next_format;
  logic [14:0] next_vstart, next_vstop;
  // Bus data phase state
  logic        wr_pend, rd_pend;
  logic [7:0]  pend_idx;
  logic        next_wr_pend, next_rd_pend;
  logic [7:0]  next_pend_idx;
  logic [31:0] next_hrdata;
  // Datapath state
  logic        counter_clear, next_counter_clear;
  logic        h_active, v_active, combined;
  logic        next_final;
  logic [15:0] div_count, next_div_count;
  logic        pixel_en;

  //////////////////////////////////////////////////////////////////////
  // Raster counters, cleared by the line reset toggle
  raster_counter counters (
    .mclk            (mclk),
    .reset_n         (reset_n),
    .pixel_en        (pixel_en),
    .clear           (counter_clear),
    .pixels_per_line (hstop_total()),
    .lines_per_field (format[LINE_W-1:0]),
    .interlaced      (format[user_timing_pkg::FMT_INTL_BIT]),
    .pos             (pos)
  );

  function automatic logic [15:0] hstop_total();
    return user_timing_pkg::PIXELS_RESET;
  endfunction

  // Index decode of a byte address; word index is address over four
  function automatic logic [7:0] reg_index(input logic [31:0] addr);
    return addr[9:2];
  endfunction

  // Window test used for both components, start included, stop excluded
  function automatic logic in_window(input logic [15:0] pos_v,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
    return (pos_v >= lo) && (pos_v < hi);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pixel rate enable divider
  always_comb begin
    pixel_en       = (div_count == 16'(PIXEL_DIV - 1));
    next_div_count = pixel_en ? 16'h0000 : div_count + 16'h0001;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= next_div_count;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bus slave: address phase captured, write applied in data phase
  always_comb begin
    logic        take;
    logic [15:0] wd;
    take          = hsel && hready && hsize == user_timing_pkg::HSIZE_WORD
                    && (htrans == user_timing_pkg::HTRANS_NONSEQ ||
                        htrans == user_timing_pkg::HTRANS_SEQ);
    wd            = hwdata[15:0];
    next_wr_pend  = take && hwrite;
    next_rd_pend  = take && !hwrite;
    next_pend_idx = take ? reg_index(haddr) : pend_idx;
    next_hstart   = hstart;
    next_hstop    = hstop;
    next_vstart   = vstart;
    next_vstop    = vstop;
    next_oper     = oper;
    next_extaud   = extaud;
    next_lnrst    = lnrst;
    next_format   = format;
    next_hrdata   = hrdata;
    if (wr_pend) begin
      case (pend_idx)
        user_timing_pkg::IDX_HSTART: next_hstart = wd;
        user_timing_pkg::IDX_HSTOP:  next_hstop  = wd;
        user_timing_pkg::IDX_VSTART: next_vstart = wd[LINE_W-1:0];
        user_timing_pkg::IDX_VSTOP:  next_vstop  = wd[LINE_W-1:0];
        user_timing_pkg::IDX_OPER:   next_oper   = {12'h000, wd[3:0]};
        user_timing_pkg::IDX_EXTAUD: next_extaud = wd;
        user_timing_pkg::IDX_LNRST:
          next_lnrst = wd & 16'h8000; // Reserved bits kept at zero
        user_timing_pkg::IDX_FORMAT: next_format = wd;
        default: ;
      endcase
    end
    // Read data registered in the address phase, ready at data phase
    if (take && !hwrite) begin
      case (reg_index(haddr))
        user_timing_pkg::IDX_HSTART: next_hrdata = {16'h0000, hstart};
        user_timing_pkg::IDX_HSTOP:  next_hrdata = {16'h0000, hstop};
        user_timing_pkg::IDX_VSTART: next_hrdata = {17'h00000, vstart};
        user_timing_pkg::IDX_VSTOP:  next_hrdata = {17'h00000, vstop};
        user_timing_pkg::IDX_OPER:   next_hrdata = {16'h0000, oper};
        user_timing_pkg::IDX_EXTAUD: next_hrdata = {16'h0000, extaud};
        user_timing_pkg::IDX_LNRST:  next_hrdata = {16'h0000, lnrst};
        user_timing_pkg::IDX_FORMAT: next_hrdata = {16'h0000, format};
        user_timing_pkg::IDX_STATUS:
          next_hrdata = {pos.field_odd, pos.line, final_signal_a,
                         extended_audio_enable, h_active, v_active,
                         12'h000};
        default:                     next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend  <= 1'b0;
      rd_pend  <= 1'b0;
      pend_idx <= 8'h00;
      hrdata   <= 32'h0000_0000;
      hstart   <= user_timing_pkg::ZERO_RESET;
      hstop    <= user_timing_pkg::ZERO_RESET;
      vstart   <= 15'h0000;
      vstop    <= 15'h0000;
      oper     <= user_timing_pkg::OPER_RESET; // see R7
      extaud   <= user_timing_pkg::ZERO_RESET;
      lnrst    <= user_timing_pkg::ZERO_RESET;
      format   <= {1'b0, user_timing_pkg::LINES_RESET};
    end else begin
      wr_pend  <= next_wr_pend;
      rd_pend  <= next_rd_pend;
      pend_idx <= next_pend_idx;
      hrdata   <= next_hrdata;
      hstart   <= next_hstart;
      hstop    <= next_hstop;
      vstart   <= next_vstart;
      vstop    <= next_vstop;
      oper     <= next_oper;
      extaud   <= next_extaud;
      lnrst    <= next_lnrst;
      format   <= next_format;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // Combination of the two components and output polarity
  always_comb begin
    // Horizontal window in pixels
    h_active = in_window(pos.pixel, hstart, hstop); // see R17 see R18
    // Odd field lines only for interlaced formats
    v_active = in_window({1'b0, pos.line}, {1'b0, vstart},
                         {1'b0, vstop}) // see R1 see R2 see R19
               && (pos.field_odd ||
                   !format[user_timing_pkg::FMT_INTL_BIT]); // see R3
    if (oper[user_timing_pkg::OPER_AND_BIT]) begin
      combined = h_active && v_active; // see R8
    end else if (oper[user_timing_pkg::OPER_OR_BIT]) begin
      combined = h_active || v_active; // see R9
    end else if (oper[user_timing_pkg::OPER_XOR_BIT]) begin
      combined = h_active ^ v_active; // see R10
    end else begin
      combined = 1'b0;
    end
    // Polarity bit high means active low
    next_final = oper[user_timing_pkg::OPER_POL_BIT] ? ~combined
                                                     : combined; // see R7
    // Any change of the reset bit restarts the counters
    next_counter_clear = (next_lnrst[user_timing_pkg::LNRST_BIT] !=
                          lnrst[user_timing_pkg::LNRST_BIT]); // see R14
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      final_signal_a        <= 1'b1;
      extended_audio_enable <= 1'b0;
      counter_clear         <= 1'b0;
    end else begin
      final_signal_a        <= next_final;
      extended_audio_enable <= (extaud ==
                                user_timing_pkg::EXTAUD_KEY); // see R11
      counter_clear         <= next_counter_clear;
    end
  end

endmodule
`default_nettype wire

// ### user_timing_pkg.sv
// Purpose: Shared constants for the user timing signal combiner
// Assumes: AHB-Lite register access, word per register
// Notes:   Printed offsets are register indexes; byte address is 4x index
package user_timing_pkg;

  // Register indexes as printed, byte address is index times four
  localparam logic [7:0] IDX_HSTART  = 8'h66;
  localparam logic [7:0] IDX_HSTOP   = 8'h67;
  localparam logic [7:0] IDX_VSTART  = 8'h68;
  localparam logic [7:0] IDX_VSTOP   = 8'h69;
  localparam logic [7:0] IDX_OPER    = 8'h6A;
  localparam logic [7:0] IDX_EXTAUD  = 8'h81;
  localparam logic [7:0] IDX_LNRST   = 8'h83;
  // Own choice: timing format and status registers
  localparam logic [7:0] IDX_FORMAT  = 8'h90;
  localparam logic [7:0] IDX_STATUS  = 8'h91;

  // Field positions
  localparam int OPER_XOR_BIT  = 0;
  localparam int OPER_OR_BIT   = 1;
  localparam int OPER_AND_BIT  = 2;
  localparam int OPER_POL_BIT  = 3;
  localparam int LNRST_BIT     = 15;
  localparam int FMT_INTL_BIT  = 15;
  localparam int LINE_W        = 15;
  localparam int REG_W         = 16;

  // Reset values and extended audio key
  localparam logic [15:0] OPER_RESET   = 16'h0008;
  localparam logic [15:0] ZERO_RESET   = 16'h0000;
  localparam logic [15:0] EXTAUD_KEY   = 16'h20C1;
  localparam logic [15:0] PIXELS_RESET = 16'h0898;
  localparam logic [14:0] LINES_RESET  = 15'h0465;
  localparam logic [14:0] FIRST_LINE   = 15'h0001;
  localparam logic [15:0] FIRST_PIXEL  = 16'h0000;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

endpackage

// ### line_position_if.sv
// Purpose: Raster position carried from counter to main block
// Assumes: One clock domain
// Notes:   Counter drives, main block reads
`timescale 1ns/10ps
`default_nettype none
interface line_position_if;
  logic [15:0] pixel;
  logic [14:0] line;
  logic        field_odd;
  modport counter (output pixel, output line, output field_odd);
  modport user    (input pixel, input line, input field_odd);
endinterface
`default_nettype wire

// ### raster_counter.sv
// Purpose: Pixel, line and field counters of the output raster
// Assumes: Pixel enable pulses once per pixel
// Notes:   Lines count from one within each field
`timescale 1ns/10ps
`default_nettype none
module raster_counter (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Control
  input  wire logic        pixel_en,
  input  wire logic        clear,
  input  wire logic [15:0] pixels_per_line,
  input  wire logic [14:0] lines_per_field,
  input  wire logic        interlaced,
  // Position
  line_position_if.counter pos
);

  logic [15:0] pixel;
  logic [14:0] line;
  logic        field_odd;
  logic [15:0] next_pixel;
  logic [14:0] next_line;
  logic        next_field_odd;

  //////////////////////////////////////////////////////////////////////
  // Next position; clear restarts at top of odd field
  always_comb begin
    next_pixel     = pixel;
    next_line      = line;
    next_field_odd = field_odd;
    if (clear) begin
      next_pixel     = user_timing_pkg::FIRST_PIXEL;
      next_line      = user_timing_pkg::FIRST_LINE;
      next_field_odd = 1'b1;
    end else if (pixel_en) begin
      if (pixel + 16'h0001 >= pixels_per_line) begin
        next_pixel = user_timing_pkg::FIRST_PIXEL;
        if (line >= lines_per_field) begin
          next_line      = user_timing_pkg::FIRST_LINE;
          next_field_odd = interlaced ? ~field_odd : 1'b1;
        end else begin
          next_line = line + 15'h0001;
        end
      end else begin
        next_pixel = pixel + 16'h0001;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pixel     <= user_timing_pkg::FIRST_PIXEL;
      line      <= user_timing_pkg::FIRST_LINE;
      field_odd <= 1'b1;
    end else begin
      pixel     <= next_pixel;
      line      <= next_line;
      field_odd <= next_field_odd;
    end
  end

  assign pos.pixel     = pixel;
  assign pos.line      = line;
  assign pos.field_odd = field_odd;

endmodule
`default_nettype wire

// ### user_timing_signal_combiner_asserts.sv
// Purpose: Port-level checks of the user timing combiner
// Assumes: Zero wait state bus, word transfers
// Notes:   Shadows operator and key writes seen on the bus
`timescale 1ns/10ps
`default_nettype none
module user_timing_signal_combiner_asserts #(
  parameter int PIXEL_DIV = 1
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Outputs
  input wire logic        final_signal_a,
  input wire logic        extended_audio_enable
);
  logic        wr_d;
  logic        rd_d;
  logic [31:0] adr;
  logic [3:0]  op_val;
  logic [2:0]  op_age;
  logic [2:0]  aud_d;
  logic        take;
  logic        aud_wr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////
  // Data phase tracking; age saturates so idle checks wait out the pipe
  assign take = hsel && hready && htrans[1] &&
                hsize == user_timing_pkg::HSIZE_WORD;
  assign aud_wr = wr_d && adr[9:2] == user_timing_pkg::IDX_EXTAUD;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_d   <= 1'b0;
      rd_d   <= 1'b0;
      adr    <= 32'h0;
      op_val <= user_timing_pkg::OPER_RESET[3:0];
      op_age <= 3'h0;
      aud_d  <= 3'h0;
    end else begin
      wr_d   <= take && hwrite;
      rd_d   <= take && !hwrite;
      adr    <= take ? haddr : adr;
      aud_d  <= {aud_d[1:0], aud_wr};
      op_age <= (op_age == 3'h7) ? op_age : op_age + 3'h1;
      if (wr_d && adr[9:2] == user_timing_pkg::IDX_OPER) begin
        op_val <= hwdata[3:0];
        op_age <= 3'h0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or not okay");
  property p_key_on; aud_wr && hwdata[15:0] == user_timing_pkg::EXTAUD_KEY
    |-> ##[1:3] extended_audio_enable; endproperty
  a_key_on: assert property (p_key_on) else $error("key ignored");
  property p_key_off; aud_wr && hwdata[15:0] != user_timing_pkg::EXTAUD_KEY
    |-> ##[1:3] !extended_audio_enable; endproperty
  a_key_off: assert property (p_key_off) else $error("bad key on");
  property p_aud_cause;
    $changed(extended_audio_enable) |-> aud_d != 3'h0; endproperty
  a_aud_cause: assert property (p_aud_cause) else $error("audio moved");
  property p_idle_level; op_age == 3'h7 && op_val[2:0] == 3'h0
    |-> final_signal_a == op_val[3]; endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level");
  property p_unmapped; rd_d && adr[31:10] == 22'h0 &&
    adr[9:2] < user_timing_pkg::IDX_HSTART |-> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_upper; rd_d && adr[9:2] != user_timing_pkg::IDX_STATUS
    |-> hrdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_op_back; rd_d && adr[9:2] == user_timing_pkg::IDX_OPER
    |-> hrdata[3:0] == op_val; endproperty
  a_op_back: assert property (p_op_back) else $error("operator read");
endmodule
bind user_timing_signal_combiner user_timing_signal_combiner_asserts
  #(.PIXEL_DIV(PIXEL_DIV)) u_chk (.mclk, .reset_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .final_signal_a, .extended_audio_enable);
`default_nettype wire

// ### tb_user_timing_signal_combiner.sv
// Purpose: Self-checking bench of the user timing combiner
// Assumes: Four-line fields so a full field is counted quickly
// Notes:   Counts active cycles per field against a pixel model
`timescale 1ns/10ps
`default_nettype none
module tb_user_timing_signal_combiner;
  logic        mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic        final_signal_a, extended_audio_enable;
  logic [31:0] haddr, hwdata, hrdata, rd, wd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  integer      mismatches, cmp_count, seed, cycles, hs, hl, cnt;
  logic [7:0]  ridx[6] = '{8'h68, 8'h69, 8'h6A, 8'h81, 8'h83, 8'h40};
  logic [31:0] rrst[6] = '{32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};
  int          ops[7] = '{4, 7, 2, 3, 1, 0, 12};
  assign hready = hreadyout;
  user_timing_signal_combiner #(.PIXEL_DIV(1)) u_dut (.mclk, .reset_n,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .final_signal_a, .extended_audio_enable);
  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end
  task tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One single transfer; the master never assumes a wait count
  task bus(input logic w, input logic [7:0] ix, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= user_timing_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, ix, 2'b00};
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  // Counter restart must land the raster on its first line
  task toggle(input logic [31:0] d);
    bus(1'b1, user_timing_pkg::IDX_LNRST, d);
    repeat (4) @(posedge mclk);
    bus(1'b0, user_timing_pkg::IDX_STATUS, 32'h0);
    check(rd[30:16], user_timing_pkg::FIRST_LINE);
  endtask
  // Sampled on the falling edge, away from output updates
  task count_win(input integer n);
    cnt = 0;
    repeat (n) begin
      @(negedge mclk);
      if (final_signal_a === 1'b1) cnt = cnt + 1;
    end
  endtask
  // Active cycles in one field of lines x 2200 pixels, one line vertical
  function automatic integer model(input integer op, input integer ln);
    integer act;
    if (op[2]) act = hl;
    else if (op[1]) act = hl * (ln - 1) + 2200;
    else if (op[0]) act = hl * (ln - 1) + 2200 - hl;
    else act = 0;
    return op[3] ? 2200 * ln - act : act;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    seed = 23730;
    {reset_n, hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = user_timing_pkg::HSIZE_WORD;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    check(final_signal_a, 32'h1);
    foreach (ridx[i]) begin
      bus(1'b0, ridx[i], 32'h0);
      check(rd, rrst[i]);
    end
    hs = $random(seed);
    wd = {16'h0, user_timing_pkg::EXTAUD_KEY ^ (hs[15:0] | 16'h0001)};
    bus(1'b1, user_timing_pkg::IDX_EXTAUD, 32'h20C1);
    repeat (4) @(posedge mclk);
    check(extended_audio_enable, 32'h1);
    bus(1'b1, user_timing_pkg::IDX_EXTAUD, wd);
    bus(1'b0, user_timing_pkg::IDX_EXTAUD, 32'h0);
    check(rd, wd);
    check(extended_audio_enable, 32'h0);
    hs = $random(seed) & 511;
    hl = 1 + ($random(seed) & 1023);
    bus(1'b1, user_timing_pkg::IDX_FORMAT, 32'h4);
    bus(1'b1, user_timing_pkg::IDX_HSTART, 32'(hs));
    bus(1'b1, user_timing_pkg::IDX_HSTOP, 32'(hs + hl));
    bus(1'b1, user_timing_pkg::IDX_VSTART, 32'h2);
    bus(1'b1, user_timing_pkg::IDX_VSTOP, 32'h3);
    toggle(32'h8000);
    foreach (ops[i]) begin
      bus(1'b1, user_timing_pkg::IDX_OPER, 32'(ops[i]));
      repeat (8) @(posedge mclk);
      count_win(8800);
      check(cnt, model(ops[i], 4));
    end
    // Interlaced: vertical window only in the odd field of each frame
    bus(1'b1, user_timing_pkg::IDX_FORMAT, 32'h8004);
    bus(1'b1, user_timing_pkg::IDX_OPER, 32'h4);
    toggle(32'h0);
    count_win(17600);
    check(cnt, model(4, 4));
    tally_and_finish();
  end
endmodule
`default_nettype wire
